// ---- core/ceds_pkg.sv ----
// Package: constants, key codes and carriers for the examine/deposit sequencer
// Summary of operation
// - Examine or start key one loads switches, then counter to address
// - Counter drive and sum drive never together
// - Address strobe from request, late tick, state three
// - Memory request high unless an inhibit term fires
// - Phase five loads run and major registers
// - Second key requested unless continue/step/start/restart
// - Second key stage loads at phase five
// - Key two reads latched address into display
// - Read cycle sets after phase five with request
// - Core read in state zero, rewrite in three
// - Memory data drive at key two state three
// - Memory high and low bytes onto adder
// - Sum drive only when all inhibits false
// - Display register loads every phase five
// - Lamp lines alternate display and counter
// - Deposit keys raise second key modify request
// - Deposit key one only latches the address
// - Deposit key two drives switches to bus
// - Modify cycle gates buffer load at tick
// - Key two end clears run, keeps stage
package ceds_pkg;

  localparam int unsigned DATA_W      = 16;
  localparam int unsigned PHASE_COUNT = 6;
  localparam logic [2:0]  PHASE_FIVE  = 3'h5;
  localparam logic [2:0]  PHASE_TS3   = 3'h3;
  localparam int unsigned RUN_W       = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_SWITCH  = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_DISPLAY = 8'h0C;
  localparam logic [7:0] OFS_COUNTER = 8'h10;

  // Field positions
  localparam int unsigned CTRL_KEY_LSB = 0;
  localparam int unsigned CTRL_GO_BIT  = 8;
  localparam logic [15:0] SWITCH_RST   = 16'h0000;

  typedef enum logic [2:0] {
    KEY_EXAMINE, KEY_EXAMINE_NEXT, KEY_DEPOSIT, KEY_DEPOSIT_NEXT,
    KEY_CONTINUE, KEY_INSTR_STEP, KEY_MEM_STEP, KEY_START
  } ceds_key_t;

  typedef enum logic [1:0] {MS_NONE, MS_KEY1, MS_KEY2} ceds_major_t;

  // Strobes toward the core memory assembly
  typedef struct packed {
    logic              addr_latch_strobe;
    logic              read_cycle_ff;
    logic              modify_cycle;
    logic              buffer_load;
    logic [DATA_W-1:0] buffer_out_bus;
  } ceds_mem_t;

  // Data path enables of one cycle
  typedef struct packed {
    logic counter_drive;
    logic sum_drive;
    logic console_data_drive;
    logic mem_data_drive;
    logic dest_right_hi_msb;
    logic dest_right_hi_lsb;
  } ceds_path_t;

endpackage

// ---- core/ceds_sequencer.sv ----
// Examine/deposit key sequencer with AHB-Lite register slave
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module ceds_sequencer (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Memory assembly
  input  wire logic [15:0] i_mem_data,
  output ceds_pkg::ceds_mem_t o_mem,
  // Inhibit terms from the rest of the processor
  input  wire logic [3:0]  i_mem_inh_a,
  input  wire logic [3:0]  i_mem_inh_b,
  input  wire logic        i_fetch_request,
  input  wire logic        i_fetch_or_pi2,
  input  wire logic        i_subroutine_jump,
  input  wire logic        i_io_read_phase,
  input  wire logic        i_interrupt_phase_a,
  input  wire logic        i_buffer_out_block,
  input  wire logic        i_restart,
  input  wire logic        i_carry,
  // Console lamps
  input  wire logic        i_lamp_supply_phase,
  output logic             o_lamp_phase_a_drive,
  output logic             o_lamp_phase_b_drive,
  output logic      [17:0] o_indicator_lines,
  // Timing and path visibility
  output logic             o_time_state_zero,
  output logic             o_time_state_three,
  output logic             o_phase_pulse_five,
  output logic             o_mem_cycle_request,
  output logic             o_display_reg_load,
  output ceds_pkg::ceds_path_t o_path
);

  typedef struct packed {
    logic [2:0]               phase;
    ceds_pkg::ceds_major_t    major;
    logic [ceds_pkg::RUN_W-1:0] run_sr;
    ceds_pkg::ceds_key_t      key;
    logic                     pending;
    logic                     read_cycle_ff;
    logic [15:0]              switches;
    logic [15:0]              counter;
    logic [15:0]              display;
    logic [15:0]              bus_out;
    logic [17:0]              lamps;
    logic                     dph_valid;
    logic                     dph_write;
    logic [7:0]               dph_addr;
    logic [31:0]              rdata;
  } ceds_state_t;

  ceds_state_t st;
  ceds_state_t next_st;

  logic        time_state_zero;
  logic        time_state_three;
  logic        phase_pulse_five;
  logic        late_phase_tick;
  logic        mem_cycle_request;
  logic        run_stage;
  logic        key1_active;
  logic        key2_active;
  logic        exam_or_dep;
  logic        dep_key;
  logic        second_key_request;
  logic        second_key_modify_req;
  logic        modify_cycle;
  logic        run_request;
  logic        addr_latch_strobe;
  ceds_pkg::ceds_path_t path;
  logic [15:0] adder_y;
  logic [15:0] adder_bus;
  logic        bus_take;
  logic        bus_go;

  // Time states: phases 0..2 are state zero, 3..5 are state three
  assign time_state_zero  = (st.phase < ceds_pkg::PHASE_TS3);
  assign time_state_three = ~time_state_zero;
  assign phase_pulse_five = (st.phase == ceds_pkg::PHASE_FIVE);
  assign late_phase_tick  = phase_pulse_five;

  assign mem_cycle_request = ~|(i_mem_inh_a & i_mem_inh_b);

  assign run_stage   = st.run_sr[0];
  assign key1_active = run_stage && (st.major == ceds_pkg::MS_KEY1);
  assign key2_active = run_stage && (st.major == ceds_pkg::MS_KEY2);
  assign exam_or_dep = (st.key == ceds_pkg::KEY_EXAMINE) || (st.key == ceds_pkg::KEY_EXAMINE_NEXT)
                    || (st.key == ceds_pkg::KEY_DEPOSIT) || (st.key == ceds_pkg::KEY_DEPOSIT_NEXT);
  assign dep_key     = (st.key == ceds_pkg::KEY_DEPOSIT) || (st.key == ceds_pkg::KEY_DEPOSIT_NEXT);

  assign second_key_request = key1_active && !i_restart
    && (st.key != ceds_pkg::KEY_CONTINUE) && (st.key != ceds_pkg::KEY_INSTR_STEP)
    && (st.key != ceds_pkg::KEY_MEM_STEP) && (st.key != ceds_pkg::KEY_START);

  assign second_key_modify_req = dep_key;
  assign modify_cycle = second_key_modify_req && key2_active;
  assign run_request  = second_key_request;

  // Address latch strobe; key two never relatches the address
  assign addr_latch_strobe = mem_cycle_request && late_phase_tick && time_state_three && key1_active;

  always_comb begin
    path = '0;
    // Switches to counter on examine or start
    // Deposit key one leaves the switches off
    path.console_data_drive = time_state_zero && ((key1_active && ((st.key == ceds_pkg::KEY_EXAMINE)
      || (st.key == ceds_pkg::KEY_EXAMINE_NEXT) || (st.key == ceds_pkg::KEY_START)))
      || (key2_active && dep_key));
    path.counter_drive = key1_active && time_state_three;
    path.mem_data_drive    = key2_active && time_state_three && exam_or_dep;
    path.dest_right_hi_msb = path.mem_data_drive;
    path.dest_right_hi_lsb = path.mem_data_drive;
    // Sum drive inhibits; key one blocks it only at state three
    path.sum_drive = !i_fetch_request && !i_fetch_or_pi2 && !(key1_active && time_state_three)
      && !i_subroutine_jump && !i_io_read_phase && !i_interrupt_phase_a && !i_buffer_out_block;
  end

  // Byte lanes of memory data onto the Y inputs
  always_comb begin
    adder_y = '0;
    if (path.dest_right_hi_msb) begin
      adder_y[15:8] = i_mem_data[15:8];
    end
    if (path.dest_right_hi_lsb) begin
      adder_y[7:0] = i_mem_data[7:0];
    end
    if (path.console_data_drive) begin
      adder_y = adder_y | st.switches;
    end
  end

  // X inputs are zero here, so the adder passes Y through
  always_comb begin
    adder_bus = '0;
    if (path.counter_drive) begin
      adder_bus = st.counter;
    end else if (path.sum_drive) begin
      adder_bus = adder_y;
    end
  end

  // Modify cycles keep the deposited word on the bus until the buffer load
  assign bus_take = path.counter_drive || (path.sum_drive && path.console_data_drive)
                 || (path.sum_drive && path.mem_data_drive && !modify_cycle);
  assign bus_go   = st.dph_valid && st.dph_write && (st.dph_addr == ceds_pkg::OFS_CTRL)
                 && hwdata[ceds_pkg::CTRL_GO_BIT];

  always_comb begin
    next_st = st;
    next_st.phase = (st.phase == ceds_pkg::PHASE_FIVE) ? 3'h0 : st.phase + 3'h1;
    if (bus_take) begin
      next_st.bus_out = adder_bus;
    end
    // Console data loads the counter in key one state zero
    if (key1_active && time_state_zero && path.console_data_drive && path.sum_drive) begin
      next_st.counter = adder_bus;
    end
    // Key two memory word lands here
    if (phase_pulse_five) begin
      next_st.display = adder_bus;
    end
    // Run and major registers load at phase five
    if (phase_pulse_five) begin
      next_st.run_sr = {st.run_sr[ceds_pkg::RUN_W-2:0], st.pending || second_key_request};
      next_st.pending = 1'b0;
      if (st.pending) begin
        next_st.major = ceds_pkg::MS_KEY1;
      end else if (second_key_request) begin
        next_st.major = ceds_pkg::MS_KEY2;
      end else if (key1_active) begin
        next_st.major = ceds_pkg::MS_NONE;
      end
      // Key two end: run falls, stage stays set
    end
    // Read cycle set after phase five; read at zero, rewrite at three
    if (phase_pulse_five) begin
      next_st.read_cycle_ff = mem_cycle_request && run_request;
    end
    // Lamp rows follow the supply phase
    // Alternate display and counter
    next_st.lamps = i_lamp_supply_phase ? {2'b00, st.display} : {i_carry, st.display[0], st.counter};
    // Key actuation is accepted only while no key sequence is running
    if (bus_go && !st.pending && !run_stage) begin
      next_st.pending = 1'b1;
      next_st.key = ceds_pkg::ceds_key_t'(hwdata[ceds_pkg::CTRL_KEY_LSB +: 3]);
    end
    if (st.dph_valid && st.dph_write && (st.dph_addr == ceds_pkg::OFS_SWITCH)) begin
      next_st.switches = hwdata[15:0];
    end
    next_st.dph_valid = hsel && hready && htrans[1];
    next_st.dph_write = hwrite;
    next_st.dph_addr  = haddr;
    next_st.rdata     = '0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr)
        ceds_pkg::OFS_CTRL:    next_st.rdata = {29'h0, st.key};
        ceds_pkg::OFS_SWITCH:  next_st.rdata = {16'h0, st.switches};
        ceds_pkg::OFS_STATUS:  next_st.rdata = {24'h0, st.read_cycle_ff, st.pending,
                                                 st.major, st.run_sr};
        ceds_pkg::OFS_DISPLAY: next_st.rdata = {16'h0, st.display};
        ceds_pkg::OFS_COUNTER: next_st.rdata = {16'h0, st.counter};
        default:               next_st.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '0;
      st.major <= ceds_pkg::MS_NONE;
      st.key <= ceds_pkg::KEY_EXAMINE;
      st.switches <= ceds_pkg::SWITCH_RST;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata    = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Buffer load at the late tick of a modify cycle
  assign o_mem.buffer_load       = modify_cycle && late_phase_tick;
  assign o_mem.addr_latch_strobe = addr_latch_strobe;
  assign o_mem.read_cycle_ff     = st.read_cycle_ff;
  assign o_mem.modify_cycle      = modify_cycle;
  assign o_mem.buffer_out_bus    = st.bus_out;
  assign o_lamp_phase_a_drive    = i_lamp_supply_phase;
  assign o_lamp_phase_b_drive    = !i_lamp_supply_phase;
  assign o_indicator_lines       = st.lamps;
  assign o_time_state_zero       = time_state_zero;
  assign o_time_state_three      = time_state_three;
  assign o_phase_pulse_five      = phase_pulse_five;
  assign o_mem_cycle_request     = mem_cycle_request;
  assign o_display_reg_load      = phase_pulse_five;
  assign o_path                  = path;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_key1_five;
    key1_active && phase_pulse_five && second_key_request;
  endsequence
  sequence s_key2_run;
    (st.major == ceds_pkg::MS_KEY2) && run_stage;
  endsequence

  property p_exclusive;
    !(path.counter_drive && path.sum_drive);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("counter and sum drive together");

  property p_strobe;
    addr_latch_strobe |-> (st.phase == 3'h5) && key1_active && mem_cycle_request;
  endproperty
  a_strobe: assert property (p_strobe) else $error("address strobe outside phase five");

  property p_reqinh;
    (|(i_mem_inh_a & i_mem_inh_b)) |-> !mem_cycle_request;
  endproperty
  a_reqinh: assert property (p_reqinh) else $error("memory request not inhibited");

  property p_key2_load;
    s_key1_five |=> s_key2_run;
  endproperty
  a_key2_load: assert property (p_key2_load) else $error("second key stage not loaded");

  property p_read_set;
    (phase_pulse_five && run_request && mem_cycle_request) |=> st.read_cycle_ff && time_state_zero;
  endproperty
  a_read_set: assert property (p_read_set) else $error("read cycle did not set");

  property p_memdrv;
    (key2_active && time_state_three && exam_or_dep) |-> path.mem_data_drive && path.dest_right_hi_lsb;
  endproperty
  a_memdrv: assert property (p_memdrv) else $error("memory data drive missing");

  property p_display;
    phase_pulse_five |=> st.display == $past(adder_bus);
  endproperty
  a_display: assert property (p_display) else $error("display not loaded");

  property p_bufload;
    o_mem.buffer_load |-> dep_key && key2_active && (st.phase == 3'h5);
  endproperty
  a_bufload: assert property (p_bufload) else $error("buffer load outside modify tick");

  property p_key2_end;
    (key2_active && phase_pulse_five) |=> !run_stage && (st.major == ceds_pkg::MS_KEY2);
  endproperty
  a_key2_end: assert property (p_key2_end) else $error("key two end wrong");

  sequence s_dep_key2_zero;
    key2_active && dep_key && time_state_zero;
  endsequence

  property p_run_hold;
    !phase_pulse_five |=> $stable(st.run_sr) && $stable(st.major);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("run or major register moved off phase five");

  property p_counter_load;
    (key1_active && time_state_zero && path.console_data_drive && path.sum_drive)
      |=> st.counter == $past(st.switches);
  endproperty
  a_counter_load: assert property (p_counter_load) else $error("counter not loaded from switches");

  property p_lanes;
    (path.mem_data_drive && !path.console_data_drive) |-> adder_y == i_mem_data;
  endproperty
  a_lanes: assert property (p_lanes) else $error("memory bytes misplaced on adder inputs");

  property p_sum_block;
    (i_fetch_request || i_fetch_or_pi2 || i_subroutine_jump || i_io_read_phase || i_interrupt_phase_a
      || i_buffer_out_block || (key1_active && time_state_three)) |-> !path.sum_drive;
  endproperty
  a_sum_block: assert property (p_sum_block) else $error("sum drive despite an inhibit");

  property p_dep_drive;
    s_dep_key2_zero |-> path.console_data_drive && (adder_y == st.switches);
  endproperty
  a_dep_drive: assert property (p_dep_drive) else $error("switches not driven in deposit key two");

  property p_dep_hold;
    (s_dep_key2_zero ##0 ((st.phase == 3'h2) && path.sum_drive))
      |-> ##3 o_mem.buffer_load && (o_mem.buffer_out_bus == $past(adder_bus, 3));
  endproperty
  a_dep_hold: assert property (p_dep_hold) else $error("deposited word lost before buffer load");

  property p_lamps;
    i_lamp_supply_phase |=> o_indicator_lines == {2'b00, $past(st.display)};
  endproperty
  a_lamps: assert property (p_lamps) else $error("display row not on lamps");

endmodule // ceds_sequencer

// ---- tb/ceds_mem_model.sv ----
// Core memory assembly model facing the examine/deposit sequencer
`timescale 1ns/1ps
module ceds_mem_model (
  // Clock
  input  wire logic           i_clk,
  // Sequencer side
  input  ceds_pkg::ceds_mem_t i_mem,
  input  wire logic           i_select,
  input  wire logic           i_rewrite_inhibit,
  output logic         [15:0] o_mem_data
);
  logic [15:0] core [256];
  logic [7:0]  addr;
  logic        rd_q;

  // Known contents so the bench can predict every read
  initial begin
    for (int i = 0; i < 256; i++) begin
      core[i] = {i[7:0], ~i[7:0]};
    end
    addr = 8'h00;
    rd_q = 1'b0;
    o_mem_data = 16'h0000;
  end

  always @(posedge i_clk) begin
    rd_q <= i_mem.read_cycle_ff;
    if (i_mem.addr_latch_strobe) begin
      addr <= i_mem.buffer_out_bus[7:0];
    end
    // Read into buffer, buffer load writes the bus word into core
    if (i_mem.read_cycle_ff && !rd_q) begin
      o_mem_data <= core[addr];
    end
    if (i_mem.buffer_load && i_select && i_rewrite_inhibit) begin
      o_mem_data <= i_mem.buffer_out_bus;
      core[addr] <= i_mem.buffer_out_bus;
    end
  end
endmodule // ceds_mem_model

// ---- tb/test_console_examine_deposit_sequencer.sv ----
// Self-checking bench for the examine/deposit sequencer
`timescale 1ns/1ps
module test_console_examine_deposit_sequencer;
  logic                 i_clk = 1'b0;
  logic                 i_sys_rst = 1'b1;
  logic                 hsel = 1'b0;
  logic [7:0]           haddr = 8'h00;
  logic [1:0]           htrans = 2'h0;
  logic                 hwrite = 1'b0;
  logic [31:0]          hwdata = 32'h0000_0000;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  logic [15:0]          mem_data;
  ceds_pkg::ceds_mem_t  mem;
  ceds_pkg::ceds_path_t path;
  logic [3:0]           inh_a = 4'h0;
  logic [3:0]           inh_b = 4'h0;
  logic [5:0]           sum_inh = 6'h00;
  logic                 carry = 1'b0;
  logic                 lamp = 1'b0;
  logic                 lamp_a;
  logic                 lamp_b;
  logic [17:0]          indicator_lines;
  logic                 ts0;
  logic                 ts3;
  logic                 pp5;
  logic                 mcr;
  logic                 drl;
  logic [15:0]          mdl [256];
  logic [15:0]          disp = 16'h0000;
  logic [15:0]          cnt = 16'h0000;
  logic [31:0]          r;
  logic [7:0]           a;
  logic                 restart = 1'b0;
  logic [17:0]          exp_ind;
  int                   ph = 0;
  int                   mismatches = 0;
  int                   checked = 0;

  always #20 i_clk = ~i_clk;
  // Reference phase count: six clocks per timing cycle
  always @(posedge i_clk) ph <= (i_sys_rst || ph == 5) ? 0 : ph + 1;

  ceds_sequencer ceds_sequencer_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .i_mem_data(mem_data), .o_mem(mem), .i_mem_inh_a(inh_a), .i_mem_inh_b(inh_b),
    .i_fetch_request(sum_inh[0]), .i_fetch_or_pi2(sum_inh[1]), .i_subroutine_jump(sum_inh[2]),
    .i_io_read_phase(sum_inh[3]), .i_interrupt_phase_a(sum_inh[4]), .i_buffer_out_block(sum_inh[5]),
    .i_restart(restart), .i_carry(carry), .i_lamp_supply_phase(lamp), .o_lamp_phase_a_drive(lamp_a),
    .o_lamp_phase_b_drive(lamp_b), .o_indicator_lines(indicator_lines), .o_time_state_zero(ts0),
    .o_time_state_three(ts3), .o_phase_pulse_five(pp5), .o_mem_cycle_request(mcr),
    .o_display_reg_load(drl), .o_path(path));

  ceds_mem_model ceds_mem_model_inst (
    .i_clk(i_clk), .i_mem(mem), .i_select(1'b1), .i_rewrite_inhibit(1'b1), .o_mem_data(mem_data));

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_reg({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic hang(input string what);
    mismatches++;
    $display("unexpected at %0t: %s timed out", $time, what);
    stop_test();
  endtask

  // Single word transfer; called right after a rising edge
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge i_clk); while (hreadyout !== 1'b1 && n++ < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_clk); while (hreadyout !== 1'b1 && n++ < 50);
    rd = hrdata;
    if (n >= 50) begin
      hang("bus");
    end
  endtask

  task automatic run_key(input logic [15:0] sw, input logic [2:0] k, input logic [1:0] mj);
    int n;
    bus(1'b1, ceds_pkg::OFS_SWITCH, {16'h0000, sw}, r);
    bus(1'b1, ceds_pkg::OFS_CTRL, {23'h0, 1'b1, 5'h00, k}, r);
    n = 0;
    do begin
      bus(1'b0, ceds_pkg::OFS_STATUS, 32'h0000_0000, r);
      n++;
    end while ((r[6] !== 1'b0 || r[0] !== 1'b0) && n < 60);
    if (n >= 60) begin
      hang("key");
    end
    cmp_reg({30'h0, r[5:4]}, {30'h0, mj}, "major state");
    cmp_bit(r[7], 1'b0, "read cycle end");
  endtask

  task automatic examine(input logic [7:0] ad, input logic [2:0] k);
    run_key({8'h00, ad}, k, 2'h2);
    disp = mdl[ad];
    bus(1'b0, ceds_pkg::OFS_DISPLAY, 32'h0000_0000, r);
    cmp_reg(r, {16'h0000, disp}, "display");
    if (k == 3'h0) begin
      cnt = {8'h00, ad};
      bus(1'b0, ceds_pkg::OFS_COUNTER, 32'h0000_0000, r);
      cmp_reg(r, {16'h0000, cnt}, "counter");
    end
  endtask

  initial begin
    void'($urandom(32'hF65E));
    for (int i = 0; i < 256; i++) begin
      mdl[i] = {i[7:0], ~i[7:0]};
    end
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF, r);
    bus(1'b0, 8'h40, 32'h0000_0000, r);
    cmp_reg(r, 32'h0000_0000, "unmapped");
    bus(1'b0, ceds_pkg::OFS_STATUS, 32'h0000_0000, r);
    cmp_reg(r, 32'h0000_0000, "status reset");
    $display("test reset done");
    restart <= 1'b1;
    run_key(16'($urandom), 3'h0, 2'h0);
    restart <= 1'b0;
    for (int k = 4; k < 8; k++) begin
      run_key(16'($urandom), 3'(k), 2'h0);
    end
    $display("test key two refusal done");
    for (int t = 0; t < 4; t++) begin
      a = 8'($urandom);
      examine(a, 3'h0);
      examine(a, 3'h1);
      mdl[a] = 16'($urandom);
      // Deposit key one must not load switches into the counter
      run_key(mdl[a], 3'h2 + 3'(t & 1), 2'h2);
      bus(1'b0, ceds_pkg::OFS_COUNTER, 32'h0000_0000, r);
      cmp_reg(r, {16'h0000, cnt}, "deposit counter");
      examine(a, 3'h0);
    end
    $display("test examine deposit done");
    // Idle phase five loads a zero adder bus into the display
    repeat (6) @(posedge i_clk);
    disp = 16'h0000;
    for (int t = 0; t < 48; t++) begin
      carry <= 1'($urandom);
      lamp <= 1'($urandom);
      sum_inh <= 6'($urandom) & {6{t[0]}};
      inh_a <= 4'($urandom);
      inh_b <= 4'($urandom);
      @(negedge i_clk);
      // Lamp register shows what the previous cycle asked for
      if (t > 0) begin
        cmp_reg({14'h0, indicator_lines}, {14'h0, exp_ind}, "lamps");
      end
      cmp_bit(mcr, ~|(inh_a & inh_b), "memory request");
      cmp_bit(path.sum_drive, ~|sum_inh, "sum drive");
      cmp_bit(drl, ph == 5, "display load");
      cmp_bit(pp5, ph == 5, "phase five");
      cmp_bit(ts0, ph < 3, "state zero");
      cmp_bit(ts3, ph > 2, "state three");
      cmp_bit(lamp_a, lamp, "lamp a");
      cmp_bit(lamp_b, ~lamp, "lamp b");
      exp_ind = lamp ? {2'b00, disp} : {carry, disp[0], cnt};
      @(posedge i_clk);
    end
    $display("test inhibits and lamps done");
    stop_test();
  end
endmodule // test_console_examine_deposit_sequencer
